// >>> dcc_defs.svh
// Constants of the delay configuration and commit register bank
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define DCC_REG_FIRST       8'h01
`define DCC_REG_LAST        8'h10
`define DCC_REG_RJ_LEN_CH1  8'h07
`define DCC_REG_COMMIT_CH1  8'h08
`define DCC_REG_RJ_LEN_CH2  8'h0f
`define DCC_REG_COMMIT_CH2  8'h10
`define DCC_REG_COUNT       16
`define DCC_RESET_BYTE      8'h00
`define DCC_STRAP_AGE       2'h2

// Offsets inside one channel group
`define DCC_OFS_CTRL        3'h0
`define DCC_OFS_RDLY_UP     3'h1
`define DCC_OFS_RDLY_LO     3'h2
`define DCC_OFS_LDLY_UP     3'h3
`define DCC_OFS_LDLY_LO     3'h4
`define DCC_OFS_FRAME       3'h5
`define DCC_OFS_RJ_LEN      3'h6
`define DCC_OFS_COMMIT      3'h7

// ****************************************************************
// Fields
// ****************************************************************
`define DCC_CTRL_MUTE_RIGHT 7
`define DCC_CTRL_MUTE_LEFT  6
`define DCC_COMMIT_BIT      0
`define DCC_DELAY_UP_MSB    4
`define DCC_FRAME_ENABLE    7
`define DCC_FRAME_RATE      6
`define DCC_FRAME_FS_MSB    5
`define DCC_FRAME_FS_LSB    3
`define DCC_FRAME_CNT_MSB   2
`define DCC_RJ_LEN_MSB      5
`define DCC_RJ_LEN_MAX      6'h18
`define DCC_DELAY_MAX       12'hfff

// ****************************************************************
// Frame delay arithmetic
// ****************************************************************
`define DCC_RATE50_DIV      32'h00000032
`define DCC_RATE5994_NUM    32'h00000032
`define DCC_RATE5994_DEN    32'h00000bb5
`define DCC_FS_32K          32'h00007d00
`define DCC_FS_44K1         32'h0000ac44
`define DCC_FS_48K          32'h0000bb80
`define DCC_FS_88K2         32'h00015888
`define DCC_FS_96K          32'h00017700
`define DCC_FS_176K4        32'h0002b110
`define DCC_FS_192K         32'h0002ee00

`endif

// >>> dcc_pkg.sv
// Types of the delay configuration and commit register bank
package dcc_pkg;

	typedef enum logic [1:0] {
		FMT_I2S,
		FMT_RIGHT_JUSTIFIED,
		FMT_LEFT_JUSTIFIED,
		FMT_BYPASS
	} dcc_format_e;

	typedef enum logic [2:0] {
		BUS_IDLE,
		BUS_ADDR,
		BUS_ADDR_ACK,
		BUS_WRITE,
		BUS_WRITE_ACK,
		BUS_READ,
		BUS_READ_ACK
	} dcc_bus_e;

	typedef struct packed {
		dcc_format_e fmt;
		logic [11:0] delayRight;
		logic [11:0] delayLeft;
		logic [5:0]  rjLength;
	} dcc_settings_s;

	typedef struct packed {
		dcc_settings_s settings;
		logic [5:0]    rjLengthApplied;
		logic          muteRight;
		logic          muteLeft;
	} dcc_active_s;

	typedef struct packed {
		logic [2:0]            toggleSync;
		logic [1:0]            muteSync1;
		logic [1:0]            muteSync2;
		logic [2:0]            wordSync;
		dcc_active_s           active;
		logic [11:0]           refillRight;
		logic [11:0]           refillLeft;
	} dcc_link_s;

	typedef struct packed {
		logic [1:0]            sclSync;
		logic [1:0]            sdaSync;
		logic                  sclPrev;
		logic                  sdaPrev;
		logic [2:0]            addrSync1;
		logic [2:0]            addrSync2;
		logic [2:0]            addrSel;
		logic                  strapDone;
		logic [1:0]            strapAge;
		dcc_bus_e              state;
		logic [2:0]            bitCnt;
		logic [7:0]            shift;
		logic                  byteDone;
		logic                  readMode;
		logic                  firstByte;
		logic [7:0]            pointer;
		logic                  sdaOe;
		logic [15:0][7:0]      regFile;
		dcc_settings_s [1:0]   staged;
		logic [1:0]            commitToggle;
	} dcc_main_s;

endpackage

// >>> dcc_channel_link.sv
// Link-clock side of one audio channel: takes commits, counts samples, mutes
`include "dcc_defs.svh"

module dcc_channel_link (
	input  logic                  linkClk,
	input  logic                  resetn,
	input  logic                  commitToggle,
	input  dcc_pkg::dcc_settings_s stagedSettings,
	input  logic [1:0]            muteRequest,
	input  logic                  wordSelect,
	output dcc_pkg::dcc_active_s  active
);

	dcc_pkg::dcc_link_s linkReg;
	dcc_pkg::dcc_link_s linkNext;

	logic commitSeen;
	logic sampleTick;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		linkNext = linkReg;
		linkNext.toggleSync = {linkReg.toggleSync[1:0], commitToggle};
		linkNext.muteSync1 = muteRequest;
		linkNext.muteSync2 = linkReg.muteSync1;
		linkNext.wordSync = {linkReg.wordSync[1:0], wordSelect};
		commitSeen = linkReg.toggleSync[2] ^ linkReg.toggleSync[1];
		sampleTick = linkReg.wordSync[1] & ~linkReg.wordSync[2];
		if (commitSeen)
		begin
			// Whole setting set switches at once
			linkNext.active.settings = stagedSettings;
			if (stagedSettings.fmt == dcc_pkg::FMT_RIGHT_JUSTIFIED)
			begin
				linkNext.active.rjLengthApplied = stagedSettings.rjLength;
			end
			else
			begin
				linkNext.active.rjLengthApplied = '0;
			end
			if (stagedSettings.fmt == dcc_pkg::FMT_BYPASS)
			begin
				linkNext.refillRight = '0;
				linkNext.refillLeft = '0;
			end
			else
			begin
				linkNext.refillRight = stagedSettings.delayRight;
				linkNext.refillLeft = stagedSettings.delayLeft;
			end
		end
		else if (sampleTick)
		begin
			// One sample per word-select period drains the refill
			if (linkReg.refillRight != '0)
			begin
				linkNext.refillRight = linkReg.refillRight - 12'h001;
			end
			if (linkReg.refillLeft != '0)
			begin
				linkNext.refillLeft = linkReg.refillLeft - 12'h001;
			end
		end
		// Direct mutes bypass the commit path
		linkNext.active.muteRight = linkReg.muteSync2[1] | (linkNext.refillRight != '0);
		linkNext.active.muteLeft = linkReg.muteSync2[0] | (linkNext.refillLeft != '0);
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge linkClk or negedge resetn)
	begin
		if (!resetn)
		begin
			linkReg <= '0;
		end
		else
		begin
			linkReg <= linkNext;
		end
	end

	assign active = linkReg.active;

endmodule

// >>> dcc_regs.sv
// Register bank with serial control port and commit to the delay engine
//
// Contract
// - Packet length applies only in right-justified format, ignored otherwise.
// - Bits five to zero of packet-length register give usable data bits.
// - Packet length above twenty-four is limited to twenty-four.
// - Writing one to commit bit zero copies staged settings to engine.
// - Writing zero to commit bit zero changes nothing.
// - Commit carries format, both delays or frame delay, and packet length.
// - After commit, mute each side until its delay in samples has passed; in pass-through format the code clears the refill and mutes neither side.
// - Format, delay and length writes act only after a commit.
// - Mute bits in control register act at once, no commit.
// - Three select inputs give eight target addresses.
// - Sequential reads advance the register address after every byte.
// - Each channel has its own packet-length and commit register.
// - Two-bit format field selects standard, right, left or pass-through.
// - Sample delays go up to 4095; zero means no delay.
// - Frame-delay top bit set derives delay from frame and sample rates.
`include "dcc_defs.svh"

module dcc_regs #(
	parameter logic [3:0] ADDR_BASE    = 4'h5,
	parameter int         NUM_CHANNELS = 2
) (
	input  logic                        ref_clk,
	input  logic                        resetn,
	input  logic                        sclIn,
	input  logic                        sdaIn,
	output logic                        sdaOut,
	output logic                        sdaOe,
	input  logic                        addrSelectLow,
	input  logic                        addrSelectMid,
	input  logic                        addrSelectHigh,
	input  logic [1:0]                  bitClk,
	input  logic [1:0]                  wordSelect,
	output dcc_pkg::dcc_active_s [1:0]  activeChannel
);

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	if (NUM_CHANNELS != 2)
	begin : gBadChannels
		$error("Register map serves exactly two channels");
	end

	dcc_pkg::dcc_main_s mainReg;
	dcc_pkg::dcc_main_s mainNext;

	logic sclRise;
	logic sclFall;
	logic busStart;
	logic busStop;
	logic [7:0] txByte;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic inRange(input logic [7:0] addr);
		return (addr >= `DCC_REG_FIRST) && (addr <= `DCC_REG_LAST);
	endfunction

	function automatic logic [3:0] regIndex(input logic [7:0] addr);
		logic [7:0] diff;
		diff = addr - `DCC_REG_FIRST;
		return diff[3:0];
	endfunction

	function automatic logic [11:0] clampDelay(input logic [12:0] raw);
		if (raw > {1'b0, `DCC_DELAY_MAX})
		begin
			return `DCC_DELAY_MAX;
		end
		return raw[11:0];
	endfunction

	function automatic logic [11:0] frameSamples(input logic [7:0] fr);
		logic [31:0] fsHz;
		logic [31:0] prod;
		logic [31:0] quot;
		unique case (fr[`DCC_FRAME_FS_MSB:`DCC_FRAME_FS_LSB])
			3'h0: fsHz = `DCC_FS_32K;
			3'h1: fsHz = `DCC_FS_44K1;
			3'h2: fsHz = `DCC_FS_48K;
			3'h3: fsHz = `DCC_FS_88K2;
			3'h4: fsHz = `DCC_FS_96K;
			3'h5: fsHz = `DCC_FS_176K4;
			3'h6: fsHz = `DCC_FS_192K;
			3'h7: fsHz = `DCC_FS_192K;
		endcase
		prod = ({29'h0, fr[`DCC_FRAME_CNT_MSB:0]} + 32'h1) * fsHz;
		if (fr[`DCC_FRAME_RATE])
		begin
			quot = (prod * `DCC_RATE5994_NUM) / `DCC_RATE5994_DEN;
		end
		else
		begin
			quot = prod / `DCC_RATE50_DIV;
		end
		if (quot > {20'h0, `DCC_DELAY_MAX})
		begin
			return `DCC_DELAY_MAX;
		end
		return quot[11:0];
	endfunction

	// Snapshot of one channel group of the register file
	function automatic dcc_pkg::dcc_settings_s settingsOf(
		input logic [15:0][7:0] regs,
		input logic             ch
	);
		dcc_pkg::dcc_settings_s s;
		logic [7:0] frame;
		logic [5:0] len;
		frame = regs[{ch, `DCC_OFS_FRAME}];
		s.fmt = dcc_pkg::dcc_format_e'(regs[{ch, `DCC_OFS_CTRL}][1:0]);
		if (frame[`DCC_FRAME_ENABLE])
		begin
			s.delayRight = frameSamples(frame);
			s.delayLeft = frameSamples(frame);
		end
		else
		begin
			s.delayRight = clampDelay({regs[{ch, `DCC_OFS_RDLY_UP}][`DCC_DELAY_UP_MSB:0],
				regs[{ch, `DCC_OFS_RDLY_LO}]});
			s.delayLeft = clampDelay({regs[{ch, `DCC_OFS_LDLY_UP}][`DCC_DELAY_UP_MSB:0],
				regs[{ch, `DCC_OFS_LDLY_LO}]});
		end
		len = regs[{ch, `DCC_OFS_RJ_LEN}][`DCC_RJ_LEN_MSB:0];
		s.rjLength = (len > `DCC_RJ_LEN_MAX) ? `DCC_RJ_LEN_MAX : len;
		return s;
	endfunction

	function automatic logic [7:0] readReg(
		input logic [15:0][7:0] regs,
		input logic [7:0]       addr
	);
		if (inRange(addr))
		begin
			return regs[regIndex(addr)];
		end
		return `DCC_RESET_BYTE;
	endfunction

	// ****************************************************************
	// Bus edge detection
	// ****************************************************************
	assign sclRise = mainReg.sclSync[1] & ~mainReg.sclPrev;
	assign sclFall = ~mainReg.sclSync[1] & mainReg.sclPrev;
	assign busStart = mainReg.sclSync[1] & mainReg.sclPrev & ~mainReg.sdaSync[1] & mainReg.sdaPrev;
	assign busStop = mainReg.sclSync[1] & mainReg.sclPrev & mainReg.sdaSync[1] & ~mainReg.sdaPrev;
	assign txByte = readReg(mainReg.regFile, mainReg.pointer);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		mainNext = mainReg;
		mainNext.sclSync = {mainReg.sclSync[0], sclIn};
		mainNext.sdaSync = {mainReg.sdaSync[0], sdaIn};
		mainNext.sclPrev = mainReg.sclSync[1];
		mainNext.sdaPrev = mainReg.sdaSync[1];
		mainNext.addrSync1 = {addrSelectHigh, addrSelectMid, addrSelectLow};
		mainNext.addrSync2 = mainReg.addrSync1;
		mainNext.strapAge = mainReg.strapAge + {1'b0, ~mainReg.strapDone};
		if (!mainReg.strapDone && (mainReg.strapAge == `DCC_STRAP_AGE))
		begin
			// Address select caught once, after both sync stages settle
			mainNext.addrSel = mainReg.addrSync2;
			mainNext.strapDone = 1'b1;
		end

		if (busStop)
		begin
			mainNext.state = dcc_pkg::BUS_IDLE;
			mainNext.sdaOe = 1'b0;
		end
		else if (busStart)
		begin
			mainNext.state = dcc_pkg::BUS_ADDR;
			mainNext.bitCnt = '0;
			mainNext.byteDone = 1'b0;
			mainNext.sdaOe = 1'b0;
		end
		else
		begin
			unique case (mainReg.state)
				dcc_pkg::BUS_IDLE:
				begin
					mainNext.sdaOe = 1'b0;
				end
				dcc_pkg::BUS_ADDR, dcc_pkg::BUS_WRITE:
				begin
					if (sclRise)
					begin
						mainNext.shift = {mainReg.shift[6:0], mainReg.sdaSync[1]};
						mainNext.bitCnt = mainReg.bitCnt + 3'h1;
						mainNext.byteDone = (mainReg.bitCnt == 3'h7);
					end
					else if (sclFall && mainReg.byteDone)
					begin
						mainNext.byteDone = 1'b0;
						if (mainReg.state == dcc_pkg::BUS_ADDR)
						begin
							if (mainReg.shift[7:1] == {ADDR_BASE, mainReg.addrSel})
							begin
								mainNext.state = dcc_pkg::BUS_ADDR_ACK;
								mainNext.readMode = mainReg.shift[0];
								mainNext.sdaOe = 1'b1;
							end
							else
							begin
								mainNext.state = dcc_pkg::BUS_IDLE;
							end
						end
						else
						begin
							mainNext.state = dcc_pkg::BUS_WRITE_ACK;
							mainNext.sdaOe = 1'b1;
							if (mainReg.firstByte)
							begin
								mainNext.pointer = mainReg.shift;
								mainNext.firstByte = 1'b0;
							end
							else
							begin
								if (inRange(mainReg.pointer))
								begin
									mainNext.regFile[regIndex(mainReg.pointer)] = mainReg.shift;
								end
								// Commit bit zero snapshots the channel; zero leaves it
								if ((mainReg.pointer == `DCC_REG_COMMIT_CH1) &&
									mainReg.shift[`DCC_COMMIT_BIT])
								begin
									mainNext.staged[0] = settingsOf(mainReg.regFile, 1'b0);
									mainNext.commitToggle[0] = ~mainReg.commitToggle[0];
								end
								if ((mainReg.pointer == `DCC_REG_COMMIT_CH2) &&
									mainReg.shift[`DCC_COMMIT_BIT])
								begin
									mainNext.staged[1] = settingsOf(mainReg.regFile, 1'b1);
									mainNext.commitToggle[1] = ~mainReg.commitToggle[1];
								end
								mainNext.pointer = mainReg.pointer + 8'h01;
							end
						end
					end
				end
				dcc_pkg::BUS_ADDR_ACK:
				begin
					if (sclFall)
					begin
						mainNext.bitCnt = '0;
						if (mainReg.readMode)
						begin
							mainNext.state = dcc_pkg::BUS_READ;
							mainNext.shift = txByte;
							mainNext.sdaOe = ~txByte[7];
							mainNext.pointer = mainReg.pointer + 8'h01;
						end
						else
						begin
							mainNext.state = dcc_pkg::BUS_WRITE;
							mainNext.firstByte = 1'b1;
							mainNext.sdaOe = 1'b0;
						end
					end
				end
				dcc_pkg::BUS_WRITE_ACK:
				begin
					if (sclFall)
					begin
						mainNext.state = dcc_pkg::BUS_WRITE;
						mainNext.sdaOe = 1'b0;
						mainNext.bitCnt = '0;
					end
				end
				dcc_pkg::BUS_READ:
				begin
					if (sclFall)
					begin
						if (mainReg.bitCnt == 3'h7)
						begin
							mainNext.state = dcc_pkg::BUS_READ_ACK;
							mainNext.sdaOe = 1'b0;
							mainNext.byteDone = 1'b0;
						end
						else
						begin
							mainNext.shift = {mainReg.shift[6:0], 1'b0};
							mainNext.sdaOe = ~mainReg.shift[6];
							mainNext.bitCnt = mainReg.bitCnt + 3'h1;
						end
					end
				end
				dcc_pkg::BUS_READ_ACK:
				begin
					if (sclRise)
					begin
						if (mainReg.sdaSync[1])
						begin
							// Not-acknowledge ends the read; wait for stop
							mainNext.state = dcc_pkg::BUS_IDLE;
						end
						else
						begin
							mainNext.byteDone = 1'b1;
						end
					end
					else if (sclFall && mainReg.byteDone)
					begin
						mainNext.state = dcc_pkg::BUS_READ;
						mainNext.byteDone = 1'b0;
						mainNext.bitCnt = '0;
						mainNext.shift = txByte;
						mainNext.sdaOe = ~txByte[7];
						mainNext.pointer = mainReg.pointer + 8'h01;
					end
				end
			endcase
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mainReg <= '0;
		end
		else
		begin
			mainReg <= mainNext;
		end
	end

	assign sdaOut = 1'b0;
	assign sdaOe = mainReg.sdaOe;

	// ****************************************************************
	// Per-channel link logic
	// ****************************************************************
	for (genvar g = 0; g < 2; g++)
	begin : gLink
		dcc_channel_link uLink (
			.linkClk        (bitClk[g]),
			.resetn         (resetn),
			.commitToggle   (mainReg.commitToggle[g]),
			.stagedSettings (mainReg.staged[g]),
			.muteRequest    ({mainReg.regFile[{g[0], `DCC_OFS_CTRL}][`DCC_CTRL_MUTE_RIGHT],
				mainReg.regFile[{g[0], `DCC_OFS_CTRL}][`DCC_CTRL_MUTE_LEFT]}),
			.wordSelect     (wordSelect[g]),
			.active         (activeChannel[g])
		);
	end

endmodule

// >>> dcc_regs_checker.sv
// Port checker of the delay configuration and commit register bank
module dcc_regs_checker (
	input logic                       ref_clk,
	input logic                       resetn,
	input logic                       sclIn,
	input logic                       sdaOut,
	input logic                       sdaOe,
	input logic [1:0]                 bitClk,
	input dcc_pkg::dcc_active_s [1:0] activeChannel
);
	timeunit 1ns;
	timeprecision 100ps;
	dcc_pkg::dcc_active_s c0;
	dcc_pkg::dcc_active_s c1;
	assign c0 = activeChannel[0];
	assign c1 = activeChannel[1];
	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_bus_open_drain: assert property (
		@(posedge ref_clk) disable iff (!resetn) sdaOut == 1'b0)
		else $error("data pin driven high");
	a_oe_scl_low: assert property (
		@(posedge ref_clk) disable iff (!resetn) $changed(sdaOe) |-> !sclIn)
		else $error("data pin moved while clock high");
	a_rj_only_ch1: assert property (
		@(posedge bitClk[0]) disable iff (!resetn)
		c0.settings.fmt != dcc_pkg::FMT_RIGHT_JUSTIFIED |-> c0.rjLengthApplied == 6'h00)
		else $error("channel one length used outside right-justified");
	a_rj_sat_ch1: assert property (
		@(posedge bitClk[0]) disable iff (!resetn)
		c0.settings.fmt == dcc_pkg::FMT_RIGHT_JUSTIFIED |-> c0.rjLengthApplied
		== (c0.settings.rjLength > 6'h18 ? 6'h18 : c0.settings.rjLength))
		else $error("channel one applied length wrong");
	a_rj_only_ch2: assert property (
		@(posedge bitClk[1]) disable iff (!resetn)
		c1.settings.fmt != dcc_pkg::FMT_RIGHT_JUSTIFIED |-> c1.rjLengthApplied == 6'h00)
		else $error("channel two length used outside right-justified");
	a_rj_sat_ch2: assert property (
		@(posedge bitClk[1]) disable iff (!resetn)
		c1.settings.fmt == dcc_pkg::FMT_RIGHT_JUSTIFIED |-> c1.rjLengthApplied
		== (c1.settings.rjLength > 6'h18 ? 6'h18 : c1.settings.rjLength))
		else $error("channel two applied length wrong");
	a_refill_right1: assert property (
		@(posedge bitClk[0]) disable iff (!resetn) $changed(c0.settings)
		&& c0.settings.delayRight != 12'h000 && c0.settings.fmt != dcc_pkg::FMT_BYPASS
		|-> c0.muteRight) else $error("channel one right not muted on commit");
	a_refill_left1: assert property (
		@(posedge bitClk[0]) disable iff (!resetn) $changed(c0.settings)
		&& c0.settings.delayLeft != 12'h000 && c0.settings.fmt != dcc_pkg::FMT_BYPASS
		|-> c0.muteLeft) else $error("channel one left not muted on commit");
	a_refill_right2: assert property (
		@(posedge bitClk[1]) disable iff (!resetn) $changed(c1.settings)
		&& c1.settings.delayRight != 12'h000 && c1.settings.fmt != dcc_pkg::FMT_BYPASS
		|-> c1.muteRight) else $error("channel two right not muted on commit");
	// ****************************************************************
	// Covers
	// ****************************************************************
	cover property (@(posedge ref_clk) $rose(sdaOe));
	cover property (@(posedge bitClk[0]) $fell(c0.muteRight));
	cover property (@(posedge bitClk[1]) $changed(c1.settings.fmt));
endmodule

bind dcc_regs dcc_regs_checker chk_u (
	.ref_clk       (ref_clk),
	.resetn        (resetn),
	.sclIn         (sclIn),
	.sdaOut        (sdaOut),
	.sdaOe         (sdaOe),
	.bitClk        (bitClk),
	.activeChannel (activeChannel)
);

// >>> dcc_i2c_master.sv
// Behavioural serial control master facing the register bank
module dcc_i2c_master (
	input  logic ref_clk,
	output logic scl,
	output logic sdaLow,
	input  logic sdaLine
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int Q = 10;
	initial
	begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// ****************************************************************
	// Bus conditions and bits
	// ****************************************************************
	task automatic startCond();
		sdaLow <= 1'b0;
		tick(Q);
		scl <= 1'b1;
		tick(Q);
		sdaLow <= 1'b1;
		tick(Q);
		scl <= 1'b0;
		tick(Q);
	endtask
	task automatic stopCond();
		sdaLow <= 1'b1;
		tick(Q);
		scl <= 1'b1;
		tick(Q);
		sdaLow <= 1'b0;
		tick(Q);
	endtask
	task automatic bitOut(input logic b);
		sdaLow <= !b;
		tick(Q);
		scl <= 1'b1;
		tick(2 * Q);
		scl <= 1'b0;
		tick(Q);
	endtask
	task automatic bitIn(output logic b);
		sdaLow <= 1'b0;
		tick(Q);
		scl <= 1'b1;
		tick(Q);
		b = sdaLine;
		tick(Q);
		scl <= 1'b0;
		tick(Q);
	endtask
	task automatic sendByte(input logic [7:0] b, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--)
			bitOut(b[i]);
		bitIn(a);
		ack = !a;
	endtask
	// Last byte of a read answered with not-acknowledge
	task automatic recvByte(input logic last, output logic [7:0] b);
		for (int i = 7; i >= 0; i--)
			bitIn(b[i]);
		bitOut(last);
	endtask
endmodule

// >>> tb_dcc_regs.sv
// Self-checking bench of the delay configuration and commit register bank
module tb_dcc_regs;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [6:0] DEV_ADDR = {4'h5, 3'b001};
	logic                       ref_clk = 1'b0;
	logic                       resetn = 1'b0;
	logic [1:0]                 bitClk = 2'b00;
	logic [1:0]                 wordSelect = 2'b00;
	logic [9:0]                 wsCnt0 = 10'h000;
	logic [9:0]                 wsCnt1 = 10'h000;
	logic [2:0]                 sel = 3'b001;
	logic                       scl;
	logic                       sdaLow;
	logic                       sdaLine;
	logic                       sdaOut;
	logic                       sdaOe;
	logic                       ack;
	logic [127:0]               rb;
	dcc_pkg::dcc_active_s [1:0] act;
	int                         n_mismatch = 0;
	int                         tests_run = 0;
	// ****************************************************************
	// Clocks, audio source, wiring
	// ****************************************************************
	always #50 ref_clk = ~ref_clk;
	always #6 bitClk[0] = ~bitClk[0];
	initial
	begin
		#2.3;
		forever #6 bitClk[1] = ~bitClk[1];
	end
	// Long word-select halves so refill outlasts a bus transfer
	always @(negedge bitClk[0])
	begin
		wsCnt0 <= wsCnt0 + 10'h001;
		if (wsCnt0 == 10'h3ff)
			wordSelect[0] <= ~wordSelect[0];
	end
	always @(negedge bitClk[1])
	begin
		wsCnt1 <= wsCnt1 + 10'h001;
		if (wsCnt1 == 10'h3ff)
			wordSelect[1] <= ~wordSelect[1];
	end
	assign sdaLine = !(sdaLow | sdaOe);
	dcc_i2c_master mst_u (
		.ref_clk (ref_clk),
		.scl     (scl),
		.sdaLow  (sdaLow),
		.sdaLine (sdaLine)
	);
	dcc_regs dut_u (
		.ref_clk        (ref_clk),
		.resetn         (resetn),
		.sclIn          (scl),
		.sdaIn          (sdaLine),
		.sdaOut         (sdaOut),
		.sdaOe          (sdaOe),
		.addrSelectLow  (sel[0]),
		.addrSelectMid  (sel[1]),
		.addrSelectHigh (sel[2]),
		.bitClk         (bitClk),
		.wordSelect     (wordSelect),
		.activeChannel  (act)
	);
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic check(input string name, input logic [127:0] exp, input logic [127:0] got);
		tests_run++;
		if (got !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", name, exp, got);
			n_mismatch++;
		end
	endtask
	task automatic complete_run();
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Bytes are taken from the top of data, one per register
	task automatic regWrite(input logic [7:0] ptr, input int n, input logic [127:0] data);
		mst_u.startCond();
		mst_u.sendByte({DEV_ADDR, 1'b0}, ack);
		check("write address ack", 128'h1, {127'h0, ack});
		mst_u.sendByte(ptr, ack);
		for (int i = 0; i < n; i++)
			mst_u.sendByte(data[127 - 8 * i -: 8], ack);
		mst_u.stopCond();
	endtask
	task automatic regRead(input logic [7:0] ptr, input int n);
		rb = 128'h0;
		mst_u.startCond();
		mst_u.sendByte({DEV_ADDR, 1'b0}, ack);
		mst_u.sendByte(ptr, ack);
		mst_u.startCond();
		mst_u.sendByte({DEV_ADDR, 1'b1}, ack);
		for (int i = 0; i < n; i++)
			mst_u.recvByte(i == n - 1, rb[127 - 8 * i -: 8]);
		mst_u.stopCond();
	endtask
	initial
	begin
		#8000000;
		n_mismatch++;
		complete_run();
	end
	// ****************************************************************
	// Tests
	// ****************************************************************
	initial
	begin
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (5) @(posedge ref_clk);
		regRead(8'h01, 16);
		check("reset registers", 128'h0, rb);
		regWrite(8'h01, 8, {64'h01000400_08003f00, 64'h0});
		repeat (40) @(posedge ref_clk);
		check("ch1 before commit", 128'h0, act[0]);
		regWrite(8'h08, 1, {8'h01, 120'h0});
		for (int k = 0; k < 300 && act[0].settings.delayRight !== 12'h004; k++)
			@(posedge ref_clk);
		check("ch1 settings", {2'h1, 12'h004, 12'h008, 6'h18}, act[0].settings);
		check("ch1 applied length", 128'h18, act[0].rjLengthApplied);
		check("ch1 refill mutes", 128'h3, {act[0].muteRight, act[0].muteLeft});
		repeat (5) @(posedge wordSelect[0]);
		check("ch1 right released", 128'h1, {act[0].muteRight, act[0].muteLeft});
		repeat (4) @(posedge wordSelect[0]);
		check("ch1 left released", 128'h0, {act[0].muteRight, act[0].muteLeft});
		regWrite(8'h01, 1, {8'hc1, 120'h0});
		repeat (10) @(posedge ref_clk);
		check("direct mutes", 128'h3, {act[0].muteRight, act[0].muteLeft});
		regWrite(8'h01, 1, {8'h01, 120'h0});
		repeat (10) @(posedge ref_clk);
		check("direct unmute", 128'h0, {act[0].muteRight, act[0].muteLeft});
		for (int f = 0; f < 4; f++)
		begin
			regWrite(8'h09, 1, {6'h0, f[1:0], 120'h0});
			regWrite(8'h0f, 2, {16'h1001, 112'h0});
			for (int k = 0; k < 300 && !(act[1].settings.fmt === f[1:0]
				&& act[1].settings.rjLength === 6'h10); k++)
				@(posedge ref_clk);
			check("ch2 format", f, act[1].settings.fmt);
			check("ch2 length", f == 1 ? 6'h10 : 6'h00, act[1].rjLengthApplied);
			check("ch1 untouched", 128'h004, act[0].settings.delayRight);
		end
		regWrite(8'h09, 8, {64'h001fff00_00001001, 64'h0});
		for (int k = 0; k < 300 && act[1].settings.delayRight !== 12'hfff; k++)
			@(posedge ref_clk);
		check("ch2 clamped delay", 128'hfff, act[1].settings.delayRight);
		check("ch2 zero left delay", 128'h2, {act[1].muteRight, act[1].muteLeft});
		regRead(8'h01, 16);
		check("all registers", 128'h01000400_08003f01_001fff00_00001001, rb);
		// Two frames at 50 Hz and 48 kHz give 1920 samples on both sides
		regWrite(8'h06, 3, {24'h913f01, 104'h0});
		for (int k = 0; k < 300 && act[0].settings.delayRight !== 12'h780; k++)
			@(posedge ref_clk);
		check("ch1 frame delay", 128'h780780,
			{act[0].settings.delayRight, act[0].settings.delayLeft});
		mst_u.startCond();
		mst_u.sendByte({DEV_ADDR ^ 7'h01, 1'b0}, ack);
		mst_u.stopCond();
		check("foreign address ack", 128'h0, {127'h0, ack});
		complete_run();
	end
endmodule
